// *** hw/eca_aux_detectors.sv ***
// eca_aux_detectors: control bits, tone detector status and gating for one
// echo canceller channel; the signal processing sits outside and feeds level flags
//
// Design decisions made here: the register offsets and the plain strobed port.
module eca_aux_detectors #(
  // cycles per millisecond for tone timing; a bench may shrink it to reach tones quickly
  parameter int MS_CYC = eca_pkg::MS_CYC
) (
  // clock and reset
  input wire logic refClk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // signal path level flags from the datapath, one cycle pulses or levels
  input wire logic pathChangeSeen,
  input wire logic residualBelowLevel,
  input wire logic rxTone2100,
  input wire logic txTone2100,
  input wire logic rxPhaseRev,
  input wire logic txPhaseRev,
  input wire logic rxQuiet,
  input wire logic txQuiet,
  input wire logic ringingSeen,
  input wire logic narrowBandSeen,
  // controls to the datapath
  output logic fastReconverge,
  output logic clearCoeffs,
  output logic suppressOn,
  output logic noiseInjectOn,
  output logic [15:0] suppressionThreshold,
  output logic advancedSuppressor,
  output logic echoRejectOn,
  output logic doubletalkRejectOn,
  output logic rampSchemeSel,
  output logic [3:0] noiseRampRate,
  output logic [7:0] noiseScaling,
  output logic ringSuppressOn,
  output logic adaptHalt,
  output logic bypassActive,
  output logic offsetFilterOn,
  output logic [1:0] toneStatus,
  output logic irq_n
);
  localparam int PLAIN_CYC = eca_pkg::TONE_PLAIN_MS * MS_CYC;
  localparam int PHASE_CYC = eca_pkg::TONE_PHASE_MS * MS_CYC;
  localparam int REL_CYC = eca_pkg::RELEASE_MS * MS_CYC;

  logic [2:0] ctrl1_r, ctrl1_nxt;
  logic [4:0] ctrl2_r, ctrl2_nxt;
  logic [6:0] ctrl3_r, ctrl3_nxt;
  logic [15:0] thresh_r, thresh_nxt;
  logic [3:0] ramp_r, ramp_nxt;
  logic [7:0] scale_r, scale_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic irqFlag_r, irqFlag_nxt;
  logic [11:0] byCnt_r, byCnt_nxt;
  logic autoBypass_r, autoBypass_nxt;
  logic [13:0] outs_r, outs_nxt;

  eca_pkg::eca_tone_e tdState_r [2];
  eca_pkg::eca_tone_e tdState_nxt [2];
  logic [24:0] tdCnt_r [2];
  logic [24:0] tdCnt_nxt [2];
  logic tdRev_r [2];
  logic tdRev_nxt [2];
  logic [1:0] tdSet, tdRel;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic [1:0] toneIn = {txTone2100, rxTone2100};
  wire logic [1:0] revIn = {txPhaseRev, rxPhaseRev};
  wire logic bothQuiet = rxQuiet & txQuiet;
  wire logic plainMode = ctrl2_r[eca_pkg::C2_PHASE_DETECTION_DISABLE];

  // tone detectors, one per input; release needs both inputs quiet
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gTone
      always_comb begin
        tdState_nxt[g] = tdState_r[g];
        tdCnt_nxt[g] = tdCnt_r[g];
        tdRev_nxt[g] = tdRev_r[g];
        tdSet[g] = 1'b0;
        tdRel[g] = 1'b0;
        unique case (tdState_r[g])
          eca_pkg::TD_IDLE: begin
            tdCnt_nxt[g] = '0;
            tdRev_nxt[g] = 1'b0;
            if (toneIn[g]) tdState_nxt[g] = eca_pkg::TD_QUAL;
          end
          eca_pkg::TD_QUAL: begin
            tdCnt_nxt[g] = tdCnt_r[g] + 25'd1;
            if (revIn[g]) tdRev_nxt[g] = 1'b1;
            if (!toneIn[g]) begin
              tdState_nxt[g] = eca_pkg::TD_IDLE;
            end else if (plainMode && tdCnt_r[g] >= 25'(PLAIN_CYC - 1)) begin
              tdState_nxt[g] = eca_pkg::TD_HELD;
              tdSet[g] = 1'b1;
            end else if (!plainMode && (tdRev_r[g] | revIn[g])
                         && tdCnt_r[g] >= 25'(PHASE_CYC - 1)) begin
              tdState_nxt[g] = eca_pkg::TD_HELD;
              tdSet[g] = 1'b1;
            end
          end
          eca_pkg::TD_HELD: begin
            tdCnt_nxt[g] = '0;
            if (bothQuiet) tdState_nxt[g] = eca_pkg::TD_REL;
          end
          eca_pkg::TD_REL: begin
            tdCnt_nxt[g] = tdCnt_r[g] + 25'd1;
            if (!bothQuiet) begin
              tdState_nxt[g] = eca_pkg::TD_HELD;
            end else if (tdCnt_r[g] >= 25'(REL_CYC - 1)) begin
              tdState_nxt[g] = eca_pkg::TD_IDLE;
              tdRel[g] = 1'b1;
            end
          end
        endcase
      end
      always_ff @(posedge refClk) begin
        if (!rst_n) begin
          tdState_r[g] <= eca_pkg::TD_IDLE;
          tdCnt_r[g] <= '0;
          tdRev_r[g] <= 1'b0;
        end else begin
          tdState_r[g] <= tdState_nxt[g];
          tdCnt_r[g] <= tdCnt_nxt[g];
          tdRev_r[g] <= tdRev_nxt[g];
        end
      end
    end
  endgenerate

  wire logic [1:0] tdHigh = {tdState_r[1][1], tdState_r[0][1]};

  // registers, interrupt flag, automatic bypass and frame hold
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    ctrl3_nxt = ctrl3_r;
    thresh_nxt = thresh_r;
    ramp_nxt = ramp_r;
    scale_nxt = scale_r;
    rdata_nxt = '0;
    irqFlag_nxt = irqFlag_r;
    autoBypass_nxt = autoBypass_r;
    if (regWr) begin
      if (hit(regAddr, eca_pkg::OFS_CTRL1)) ctrl1_nxt = regWdata[2:0];
      if (hit(regAddr, eca_pkg::OFS_CTRL2)) ctrl2_nxt = regWdata[4:0];
      if (hit(regAddr, eca_pkg::OFS_THRESH)) thresh_nxt = regWdata;
      if (hit(regAddr, eca_pkg::OFS_NOISECTL)) ramp_nxt = regWdata[3:0];
      if (hit(regAddr, eca_pkg::OFS_NOISESCL)) scale_nxt = regWdata[7:0];
      if (hit(regAddr, eca_pkg::OFS_CTRL3)) begin
        ctrl3_nxt = regWdata[6:0];
        // original suppressor lacks the advanced features
        if (!regWdata[eca_pkg::C3_TYPESEL]) begin
          ctrl3_nxt[eca_pkg::C3_ECHOREJ] = 1'b0;
          ctrl3_nxt[eca_pkg::C3_DTREJ] = 1'b0;
          ctrl3_nxt[eca_pkg::C3_RAMPSEL] = 1'b0;
        end
        // switching type loads that type's noise defaults
        if (regWdata[eca_pkg::C3_TYPESEL] != ctrl3_r[eca_pkg::C3_TYPESEL]) begin
          ramp_nxt = regWdata[eca_pkg::C3_TYPESEL] ? eca_pkg::RAMP_ADV : eca_pkg::RAMP_ORIG;
          scale_nxt = regWdata[eca_pkg::C3_TYPESEL] ? eca_pkg::SCALE_ADV
                                                    : eca_pkg::SCALE_ORIG;
        end
      end
    end
    if (regRd) begin
      unique case (regAddr)
        eca_pkg::OFS_CTRL1: rdata_nxt = {13'h0000, ctrl1_r};
        eca_pkg::OFS_CTRL2: rdata_nxt = {11'h000, ctrl2_r};
        eca_pkg::OFS_CTRL3: rdata_nxt = {9'h000, ctrl3_r};
        eca_pkg::OFS_THRESH: rdata_nxt = thresh_r;
        eca_pkg::OFS_NOISECTL: rdata_nxt = {12'h000, ramp_r};
        eca_pkg::OFS_NOISESCL: rdata_nxt = {8'h00, scale_r};
        eca_pkg::OFS_STATUS: rdata_nxt = {13'h0000, irqFlag_r, tdHigh};
        default: rdata_nxt = '0;
      endcase
    end
    // status read acknowledges; a new event in the same cycle wins
    if (regRd && hit(regAddr, eca_pkg::OFS_STATUS)) irqFlag_nxt = 1'b0;
    if (|tdSet || |tdRel) irqFlag_nxt = 1'b1;
    if (ctrl2_r[eca_pkg::C2_AUTOTONE]) begin
      if (|tdSet) autoBypass_nxt = 1'b1;
      else if (tdHigh == 2'b00) autoBypass_nxt = 1'b0;
    end else begin
      autoBypass_nxt = 1'b0;
    end
  end

  wire logic bypassReq = ctrl1_r[eca_pkg::C1_BYPASS] | autoBypass_r;

  // bypass stays at least one frame so coefficient clearing completes
  always_comb begin
    byCnt_nxt = byCnt_r;
    if (bypassReq && byCnt_r == '0) byCnt_nxt = 12'(eca_pkg::FRAME_CYC - 1);
    else if (byCnt_r != '0) byCnt_nxt = byCnt_r - 12'd1;
  end

  wire logic bypassNow = bypassReq | (byCnt_r != '0);
  wire logic supOn = ~ctrl2_r[eca_pkg::C2_SUPDIS];

  always_comb begin
    outs_nxt[0] = ctrl3_r[eca_pkg::C3_PATHEN] & pathChangeSeen;
    outs_nxt[1] = (ctrl3_r[eca_pkg::C3_PATHEN] & ctrl3_r[eca_pkg::C3_PATH_CHANGE_CLEAR_ENABLE]
                   & pathChangeSeen) | bypassNow;
    outs_nxt[2] = supOn & residualBelowLevel & ~bypassNow;
    outs_nxt[3] = supOn & ~ctrl1_r[eca_pkg::C1_NOISE_INJECTION_DISABLE] & residualBelowLevel;
    outs_nxt[4] = ctrl3_r[eca_pkg::C3_TYPESEL];
    outs_nxt[5] = ctrl3_r[eca_pkg::C3_ECHOREJ];
    outs_nxt[6] = ctrl3_r[eca_pkg::C3_DTREJ];
    outs_nxt[7] = ctrl3_r[eca_pkg::C3_RAMPSEL];
    outs_nxt[8] = ctrl3_r[eca_pkg::C3_RINGEN] & ringingSeen;
    outs_nxt[9] = ctrl1_r[eca_pkg::C1_ADAPTDIS]
                  | (~ctrl2_r[eca_pkg::C2_NARROW_BAND_DETECTOR_DISABLE] & narrowBandSeen);
    outs_nxt[10] = bypassNow;
    outs_nxt[11] = ~ctrl2_r[eca_pkg::C2_OFSDIS];
    outs_nxt[12] = ~irqFlag_nxt;
    outs_nxt[13] = 1'b0;
  end

  always_ff @(posedge refClk) begin
    if (!rst_n) begin
      ctrl1_r <= '0;
      ctrl2_r <= '0;
      ctrl3_r <= eca_pkg::CTRL3_RST[6:0];
      thresh_r <= eca_pkg::THRESH_RST;
      ramp_r <= eca_pkg::RAMP_ADV;
      scale_r <= eca_pkg::SCALE_ADV;
      rdata_r <= '0;
      irqFlag_r <= 1'b0;
      autoBypass_r <= 1'b0;
      byCnt_r <= '0;
      outs_r <= 14'h1800;
    end else begin
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      ctrl3_r <= ctrl3_nxt;
      thresh_r <= thresh_nxt;
      ramp_r <= ramp_nxt;
      scale_r <= scale_nxt;
      rdata_r <= rdata_nxt;
      irqFlag_r <= irqFlag_nxt;
      autoBypass_r <= autoBypass_nxt;
      byCnt_r <= byCnt_nxt;
      outs_r <= outs_nxt;
    end
  end

  // threshold only matters while the suppressor runs; datapath gates it by suppressOn
  assign regRdata = rdata_r;
  assign fastReconverge = outs_r[0];
  assign clearCoeffs = outs_r[1];
  assign suppressOn = outs_r[2];
  assign noiseInjectOn = outs_r[3];
  assign suppressionThreshold = thresh_r;
  assign advancedSuppressor = outs_r[4];
  assign echoRejectOn = outs_r[5];
  assign doubletalkRejectOn = outs_r[6];
  assign rampSchemeSel = outs_r[7];
  assign noiseRampRate = ramp_r;
  assign noiseScaling = scale_r;
  assign ringSuppressOn = outs_r[8];
  assign adaptHalt = outs_r[9];
  assign bypassActive = outs_r[10];
  assign offsetFilterOn = outs_r[11];
  assign toneStatus = tdHigh;
  assign irq_n = outs_r[12];

  // assertions
  rd_timing_a: assert property (@(posedge refClk) disable iff (!rst_n)
    regRd && regAddr == eca_pkg::OFS_THRESH |=> regRdata == $past(thresh_r))
    else $error("threshold read data wrong");
  path_gate_a: assert property (@(posedge refClk) disable iff (!rst_n)
    fastReconverge |-> $past(ctrl3_r[eca_pkg::C3_PATHEN]))
    else $error("reconvergence without enable");
  clear_path_a: assert property (@(posedge refClk) disable iff (!rst_n)
    pathChangeSeen && ctrl3_r[0] && ctrl3_r[1] |=> clearCoeffs)
    else $error("path clear missed");
  sup_off_a: assert property (@(posedge refClk) disable iff (!rst_n)
    ctrl2_r[eca_pkg::C2_SUPDIS] |=> !suppressOn && !noiseInjectOn)
    else $error("suppressor active while disabled");
  inj_off_a: assert property (@(posedge refClk) disable iff (!rst_n)
    ctrl1_r[eca_pkg::C1_NOISE_INJECTION_DISABLE] |=> !noiseInjectOn)
    else $error("noise injected while disabled");
  orig_feat_a: assert property (@(posedge refClk) disable iff (!rst_n)
    !ctrl3_r[eca_pkg::C3_TYPESEL] |-> ctrl3_r[5:3] == 3'b000)
    else $error("advanced feature set in original mode");
  tone_irq_a: assert property (@(posedge refClk) disable iff (!rst_n)
    |tdSet |=> !irq_n ##1 toneStatus != 2'b00)
    else $error("tone detection not signalled");
  nb_halt_a: assert property (@(posedge refClk) disable iff (!rst_n)
    narrowBandSeen && !ctrl2_r[eca_pkg::C2_NARROW_BAND_DETECTOR_DISABLE] |=> adaptHalt)
    else $error("narrow band did not halt adaptation");
  ofs_filt_a: assert property (@(posedge refClk) disable iff (!rst_n)
    ctrl2_r[eca_pkg::C2_OFSDIS] |=> !offsetFilterOn)
    else $error("offset filter not bypassed");
  bypass_hold_a: assert property (@(posedge refClk) disable iff (!rst_n)
    $rose(bypassActive) |-> bypassActive[*8])
    else $error("bypass dropped early");
  auto_byp_a: assert property (@(posedge refClk) disable iff (!rst_n)
    |tdSet && ctrl2_r[eca_pkg::C2_AUTOTONE] |=> ##1 bypassActive)
    else $error("automatic bypass missed");
  rel_irq_a: assert property (@(posedge refClk) disable iff (!rst_n)
    |tdRel |=> !irq_n)
    else $error("tone release not signalled");
  stat_clear_a: assert property (@(posedge refClk) disable iff (!rst_n)
    regRd && regAddr == eca_pkg::OFS_STATUS && tdSet == 2'b00 && tdRel == 2'b00 |=> irq_n)
    else $error("status read left interrupt pending");
  qual_drop_a: assert property (@(posedge refClk) disable iff (!rst_n)
    tdState_r[0] == eca_pkg::TD_QUAL && !rxTone2100 |=> tdState_r[0] == eca_pkg::TD_IDLE)
    else $error("tone qualification not restarted");
endmodule : eca_aux_detectors

// *** hw/eca_pkg.sv ***
// eca_pkg: register offsets, field positions, reset values and timing counts
// for the per-channel auxiliary detector block; assumes a 20 MHz ref_clk
package eca_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYC = FRAME_NS / 50;
  localparam int TONE_PLAIN_MS = 400;
  localparam int TONE_PHASE_MS = 1000;
  localparam int RELEASE_MS = 400;
  localparam int MS_CYC = CLK_HZ / 1000;
  // register offsets (word index on the plain port)
  localparam logic [3:0] OFS_CTRL1 = 4'h0;
  localparam logic [3:0] OFS_CTRL2 = 4'h1;
  localparam logic [3:0] OFS_CTRL3 = 4'h2;
  localparam logic [3:0] OFS_THRESH = 4'h3;
  localparam logic [3:0] OFS_NOISECTL = 4'h4;
  localparam logic [3:0] OFS_NOISESCL = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;
  // control register 1 fields
  localparam int C1_NOISE_INJECTION_DISABLE = 0;
  localparam int C1_BYPASS = 1;
  localparam int C1_ADAPTDIS = 2;
  // control register 2 fields
  localparam int C2_SUPDIS = 0;
  localparam int C2_PHASE_DETECTION_DISABLE = 1;
  localparam int C2_AUTOTONE = 2;
  localparam int C2_NARROW_BAND_DETECTOR_DISABLE = 3;
  localparam int C2_OFSDIS = 4;
  // control register 3 fields
  localparam int C3_PATHEN = 0;
  localparam int C3_PATH_CHANGE_CLEAR_ENABLE = 1;
  localparam int C3_TYPESEL = 2;
  localparam int C3_ECHOREJ = 3;
  localparam int C3_DTREJ = 4;
  localparam int C3_RAMPSEL = 5;
  localparam int C3_RINGEN = 6;
  // reset values and the noise defaults of each suppressor type
  localparam logic [7:0] CTRL3_RST = 8'h3d;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [3:0] RAMP_ADV = 4'h5;
  localparam logic [3:0] RAMP_ORIG = 4'hc;
  localparam logic [7:0] SCALE_ADV = 8'h16;
  localparam logic [7:0] SCALE_ORIG = 8'h74;
  typedef enum logic [1:0] {
    TD_IDLE = 2'b00,
    TD_QUAL = 2'b01,
    TD_HELD = 2'b10,
    TD_REL = 2'b11
  } eca_tone_e;
endpackage : eca_pkg

// *** verif/eca_aux_detectors_tb.sv ***
// eca_aux_detectors_tb: register and flag sequences with expected values
// assumes eca_pkg and eca_ctl_model are compiled first; tone times shrink through MS_CYC
module eca_aux_detectors_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic refClk = 1'b0;
  logic rst_n = 1'b0;
  logic svcEn = 1'b1;
  logic pathChangeSeen = 1'b0, residualBelowLevel = 1'b0, rxTone2100 = 1'b0;
  logic txTone2100 = 1'b0, rxPhaseRev = 1'b0, txPhaseRev = 1'b0, rxQuiet = 1'b1;
  logic txQuiet = 1'b1, ringingSeen = 1'b0, narrowBandSeen = 1'b0;
  logic [3:0] regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic regWr, regRd, fastReconverge, clearCoeffs, suppressOn, noiseInjectOn;
  logic advancedSuppressor, echoRejectOn, doubletalkRejectOn, rampSchemeSel;
  logic ringSuppressOn, adaptHalt, bypassActive, offsetFilterOn, irq_n;
  logic [15:0] suppressionThreshold;
  logic [3:0] noiseRampRate;
  logic [7:0] noiseScaling;
  logic [1:0] toneStatus;
  int n_errors = 0;
  int total_checks = 0;
  logic [15:0] thv [3] = '{16'h4800, 16'h7fff, 16'hffff};
  logic [7:0] c3v [5] = '{8'h35, 8'h2d, 8'h1d, 8'h7d, 8'h3d};
  logic [3:0] c3e [5] = '{4'h6, 4'ha, 4'hc, 4'hf, 4'he};
  logic [7:0] c2v [4] = '{8'h00, 8'h01, 8'h08, 8'h10};
  logic [3:0] c2e [4] = '{4'hf, 4'h3, 4'hd, 4'he};

  // four cycles per millisecond keeps every tone time inside the run
  eca_aux_detectors #(.MS_CYC(4)) uut (
    .refClk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .pathChangeSeen, .residualBelowLevel, .rxTone2100, .txTone2100, .rxPhaseRev,
    .txPhaseRev, .rxQuiet, .txQuiet, .ringingSeen, .narrowBandSeen, .fastReconverge,
    .clearCoeffs, .suppressOn, .noiseInjectOn, .suppressionThreshold, .advancedSuppressor,
    .echoRejectOn, .doubletalkRejectOn, .rampSchemeSel, .noiseRampRate, .noiseScaling,
    .ringSuppressOn, .adaptHalt, .bypassActive, .offsetFilterOn, .toneStatus, .irq_n);
  eca_ctl_model ctl (.refClk, .svcEn, .irq_n, .regRdata, .regAddr, .regWdata, .regWr,
    .regRd);

  initial begin
    forever #25 refClk = ~refClk;
  end

  task automatic give_verdict;
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string n);
    logic [15:0] v;
    ctl.rd(a, v);
    chk(n, e, v);
  endtask : rdc
  task automatic settle;
    repeat (3) @(posedge refClk);
    #1;
  endtask : settle
  // a path pulse, then the two path outputs gathered over four cycles
  task automatic path(output logic [15:0] r);
    @(posedge refClk);
    pathChangeSeen <= 1'b1;
    @(posedge refClk);
    pathChangeSeen <= 1'b0;
    r = 16'h0000;
    // the outputs stand one cycle, from the edge that takes the pulse
    repeat (4) begin
      #1;
      r = r | {14'h0000, fastReconverge, clearCoeffs};
      @(posedge refClk);
    end
  endtask : path

  initial begin
    repeat (60000) @(posedge refClk);
    n_errors++;
    give_verdict();
  end

  initial begin
    logic [15:0] r;
    repeat (20) @(posedge refClk);
    rst_n <= 1'b1;
    settle();
    rdc(eca_pkg::OFS_CTRL3, 16'h003d, "ctrl3");
    rdc(eca_pkg::OFS_NOISECTL, 16'h0005, "rampReg");
    rdc(eca_pkg::OFS_NOISESCL, 16'h0016, "scaleReg");
    chk("nlpOuts", 16'h000f, {12'h000, advancedSuppressor, echoRejectOn,
      doubletalkRejectOn, rampSchemeSel});
    chk("noiseOuts", 16'h0516, {4'h0, noiseRampRate, noiseScaling});
    chk("idleOuts", 16'h0003, {12'h000, toneStatus, irq_n, offsetFilterOn});
    path(r);
    chk("pathEnOnly", 16'h0002, r);
    ctl.wr(eca_pkg::OFS_CTRL3, 16'h003f);
    path(r);
    chk("pathClear", 16'h0003, r);
    ctl.wr(eca_pkg::OFS_CTRL3, 16'h003c);
    path(r);
    chk("pathOff", 16'h0000, r);
    // original suppressor: feature bits read back zero, defaults reload
    ctl.wr(eca_pkg::OFS_CTRL3, 16'h0039);
    settle();
    rdc(eca_pkg::OFS_CTRL3, 16'h0001, "ctrl3Orig");
    rdc(eca_pkg::OFS_NOISECTL, 16'h000c, "rampOrig");
    rdc(eca_pkg::OFS_NOISESCL, 16'h0074, "scaleOrig");
    chk("origOuts", 16'h0000, {12'h000, advancedSuppressor, echoRejectOn,
      doubletalkRejectOn, rampSchemeSel});
    chk("origNoise", 16'h0c74, {4'h0, noiseRampRate, noiseScaling});
    ringingSeen <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      ctl.wr(eca_pkg::OFS_CTRL3, {8'h00, c3v[i]});
      settle();
      chk("ctrl3Outs", {12'h000, c3e[i]}, {12'h000, echoRejectOn, doubletalkRejectOn,
        rampSchemeSel, ringSuppressOn});
    end
    chk("advNoise", 16'h0516, {4'h0, noiseRampRate, noiseScaling});
    ctl.wr(eca_pkg::OFS_NOISECTL, 16'h001f);
    rdc(eca_pkg::OFS_NOISECTL, 16'h000f, "rampWide");
    ctl.wr(eca_pkg::OFS_NOISESCL, 16'h0042);
    rdc(eca_pkg::OFS_NOISESCL, 16'h0042, "scaleSet");
    for (int i = 0; i < 3; i++) begin
      ctl.wr(eca_pkg::OFS_THRESH, thv[i]);
      rdc(eca_pkg::OFS_THRESH, thv[i], "threshReg");
      settle();
      chk("threshOut", thv[i], suppressionThreshold);
    end
    residualBelowLevel <= 1'b1;
    narrowBandSeen <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ctl.wr(eca_pkg::OFS_CTRL2, {8'h00, c2v[i]});
      settle();
      chk("ctrl2Outs", {12'h000, c2e[i]}, {12'h000, suppressOn, noiseInjectOn,
        adaptHalt, offsetFilterOn});
    end
    ctl.wr(eca_pkg::OFS_CTRL2, 16'h0008);
    ctl.wr(eca_pkg::OFS_CTRL1, 16'h0005);
    settle();
    chk("noise_injection_disable", 16'h0005, {13'h0000, suppressOn, noiseInjectOn, adaptHalt});
    ctl.wr(eca_pkg::OFS_CTRL1, 16'h0000);
    residualBelowLevel <= 1'b0;
    settle();
    chk("residHigh", 16'h0000, {13'h0000, suppressOn, noiseInjectOn, adaptHalt});
    // a tone far shorter than the plain-mode hold must not qualify
    ctl.wr(eca_pkg::OFS_CTRL2, 16'h0002);
    rxTone2100 <= 1'b1;
    txTone2100 <= 1'b1;
    rxQuiet <= 1'b0;
    txQuiet <= 1'b0;
    repeat (1000) @(posedge refClk);
    rxTone2100 <= 1'b0;
    txTone2100 <= 1'b0;
    settle();
    chk("shortTone", 16'h0001, {13'h0000, toneStatus, irq_n});
    rdc(eca_pkg::OFS_STATUS, 16'h0000, "status");
    ctl.wr(4'hf, 16'hffff);
    rdc(4'h7, 16'h0000, "unmapped");
    rdc(eca_pkg::OFS_CTRL1, 16'h0000, "ctrl1Kept");
    ctl.wr(eca_pkg::OFS_CTRL1, 16'h0002);
    settle();
    chk("bypassOn", 16'h0003, {14'h0000, bypassActive, clearCoeffs});
    // dropping the bit at once must not cut the clearing frame short
    ctl.wr(eca_pkg::OFS_CTRL1, 16'h0000);
    repeat (2400) @(posedge refClk);
    #1;
    chk("bypassHeld", 16'h0001, {15'h0000, bypassActive});
    repeat (100) @(posedge refClk);
    #1;
    chk("bypassDrop", 16'h0000, {14'h0000, bypassActive, clearCoeffs});
    // plain mode with the controller model answering the interrupt itself
    @(posedge refClk);
    rxTone2100 <= 1'b1;
    repeat (1700) @(posedge refClk);
    #1;
    chk("svcBypass", 16'h0007, {12'h000, toneStatus, irq_n, bypassActive});
    @(posedge refClk);
    svcEn <= 1'b0;
    rxTone2100 <= 1'b0;
    repeat (100) @(posedge refClk);
    rdc(eca_pkg::OFS_STATUS, 16'h0001, "statusHeld");
    @(posedge refClk);
    rxQuiet <= 1'b1;
    txQuiet <= 1'b1;
    repeat (1700) @(posedge refClk);
    #1;
    chk("releaseIrq", 16'h0000, {13'h0000, toneStatus, irq_n});
    rdc(eca_pkg::OFS_STATUS, 16'h0004, "statusRel");
    // automatic bypass in phase mode: no reversal, no trigger
    ctl.wr(eca_pkg::OFS_CTRL1, 16'h0000);
    ctl.wr(eca_pkg::OFS_CTRL2, 16'h0004);
    txTone2100 <= 1'b1;
    txQuiet <= 1'b0;
    repeat (4100) @(posedge refClk);
    #1;
    chk("noReversal", 16'h0000, {13'h0000, toneStatus, bypassActive});
    @(posedge refClk);
    txPhaseRev <= 1'b1;
    @(posedge refClk);
    txPhaseRev <= 1'b0;
    repeat (3) @(posedge refClk);
    #1;
    chk("autoBypass", 16'h0009, {12'h000, toneStatus, irq_n, bypassActive});
    @(posedge refClk);
    txTone2100 <= 1'b0;
    txQuiet <= 1'b1;
    repeat (4300) @(posedge refClk);
    #1;
    chk("autoRelease", 16'h0000, {13'h0000, toneStatus, bypassActive});
    rdc(eca_pkg::OFS_STATUS, 16'h0004, "statusAuto");
    give_verdict();
  end
endmodule : eca_aux_detectors_tb

// *** verif/eca_ctl_model.sv ***
// eca_ctl_model: external controller on the register port of one channel
// assumes one refClk domain; the bench calls wr and rd through this instance
module eca_ctl_model (
  // clock and service enable
  input wire logic refClk,
  input wire logic svcEn,
  // register port
  input wire logic irq_n,
  input wire logic [15:0] regRdata,
  output logic [3:0] regAddr,
  output logic [15:0] regWdata,
  output logic regWr,
  output logic regRd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  logic [15:0] st;
  initial begin
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // busy keeps the service loop and the bench off the port at the same time
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    while (busy) @(posedge refClk);
    busy = 1'b1;
    @(posedge refClk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge refClk);
    regWr <= 1'b0;
    busy = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    while (busy) @(posedge refClk);
    busy = 1'b1;
    @(posedge refClk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge refClk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
    busy = 1'b0;
  endtask : rd
  // without automatic bypass the controller answers a tone report itself
  initial begin
    forever begin
      @(posedge refClk);
      if (svcEn && irq_n === 1'b0) begin
        rd(eca_pkg::OFS_STATUS, st);
        // bypass is set and kept, never dropped within one frame
        if (st[1:0] != 2'b00) wr(eca_pkg::OFS_CTRL1, 16'h0002);
      end
    end
  end
endmodule : eca_ctl_model
